// >>> pkg/cam_pkg.sv
// constants and types shared by the address mode decoder
// assumes one 50 MHz core clock; no software-visible registers
package cam_pkg;

   // addressing modes, gray along inh-imm-dir-ext-rel-ix-ix1-ix2
   typedef enum logic [3:0] {
      CAM_MODE_INH = 4'h0,
      CAM_MODE_IMM = 4'h1,
      CAM_MODE_DIR = 4'h3,
      CAM_MODE_EXT = 4'h2,
      CAM_MODE_REL = 4'h6,
      CAM_MODE_IX  = 4'h7,
      CAM_MODE_IX1 = 4'h5,
      CAM_MODE_IX2 = 4'h4,
      CAM_MODE_BSC = 4'hc,
      CAM_MODE_BTB = 4'hd,
      CAM_MODE_BAD = 4'hf
   } cam_mode_type;

   // port direction registers read back as all ones
   localparam logic [15:0] CAM_DDR_FIRST = 16'h0004;
   localparam logic [15:0] CAM_DDR_LAST  = 16'h0006;
   localparam logic [7:0]  CAM_DDR_READ  = 8'hff;

   // special opcodes
   localparam logic [7:0] CAM_OP_BSR = 8'had;
   localparam logic [7:0] CAM_OP_RTI = 8'h80;
   localparam logic [7:0] CAM_OP_RTS = 8'h81;
   localparam logic [7:0] CAM_OP_SWI = 8'h83;

   // register/memory and read-modify-write low nibbles
   localparam logic [3:0] CAM_LO_CMPA = 4'h1;
   localparam logic [3:0] CAM_LO_CMPX = 4'h3;
   localparam logic [3:0] CAM_LO_BITT = 4'h5;
   localparam logic [3:0] CAM_LO_STA  = 4'h7;
   localparam logic [3:0] CAM_LO_JMP  = 4'hc;
   localparam logic [3:0] CAM_LO_JSR  = 4'hd;
   localparam logic [3:0] CAM_LO_LDX  = 4'he;
   localparam logic [3:0] CAM_LO_STX  = 4'hf;
   localparam logic [3:0] CAM_LO_TST  = 4'hd;

   // instruction lengths in bytes
   localparam logic [1:0] CAM_LEN_ONE   = 2'd1;
   localparam logic [1:0] CAM_LEN_TWO   = 2'd2;
   localparam logic [1:0] CAM_LEN_THREE = 2'd3;

   // cycle counts
   localparam logic [3:0] CAM_CYC_LD_IMM   = 4'd2;
   localparam logic [3:0] CAM_CYC_LD_DIR   = 4'd4;
   localparam logic [3:0] CAM_CYC_LD_EXT   = 4'd5;
   localparam logic [3:0] CAM_CYC_LD_IX    = 4'd4;
   localparam logic [3:0] CAM_CYC_LD_IX1   = 4'd5;
   localparam logic [3:0] CAM_CYC_LD_IX2   = 4'd6;
   localparam logic [3:0] CAM_CYC_ST_MORE  = 4'd1;
   localparam logic [3:0] CAM_CYC_JMP_LESS = 4'd1;
   localparam logic [3:0] CAM_CYC_JSR_MORE = 4'd3;
   localparam logic [3:0] CAM_CYC_RMW_INH  = 4'd4;
   localparam logic [3:0] CAM_CYC_RMW_DIR  = 4'd6;
   localparam logic [3:0] CAM_CYC_RMW_IX   = 4'd6;
   localparam logic [3:0] CAM_CYC_RMW_IX1  = 4'd7;
   localparam logic [3:0] CAM_CYC_REL      = 4'd4;
   localparam logic [3:0] CAM_CYC_BSR      = 4'd8;
   localparam logic [3:0] CAM_CYC_BSC      = 4'd7;
   localparam logic [3:0] CAM_CYC_BTB      = 4'd10;
   localparam logic [3:0] CAM_CYC_RTI      = 4'd9;
   localparam logic [3:0] CAM_CYC_RTS      = 4'd6;
   localparam logic [3:0] CAM_CYC_SWI      = 4'd11;
   localparam logic [3:0] CAM_CYC_CTL      = 4'd2;

   // values after reset
   localparam logic [15:0] CAM_RST_ADDR = 16'h0000;
   localparam logic [7:0]  CAM_RST_BYTE = 8'h00;
   localparam logic [3:0]  CAM_RST_CYC  = 4'h0;

endpackage : cam_pkg

// >>> core/cam_ea_calc.sv
// effective address adder for the direct, extended, indexed and bit modes; other modes give zero
// assumes operand bytes and index come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module cam_ea_calc (
   input  wire cam_pkg::cam_mode_type mode,
   input  wire logic [7:0]            byte2,
   input  wire logic [7:0]            byte3,
   input  wire logic [7:0]            index_x,
   output logic      [15:0]           effective_address
);
   import cam_pkg::*;

   wire [15:0] page0_w = {8'h00, byte2};
   wire [15:0] full_w  = {byte2, byte3};
   wire [15:0] idx_w   = {8'h00, index_x};

   assign effective_address =
      (mode == CAM_MODE_DIR) ? page0_w :
      (mode == CAM_MODE_EXT) ? full_w :
      (mode == CAM_MODE_IX)  ? idx_w :
      (mode == CAM_MODE_IX1) ? 16'(page0_w + idx_w) :
      (mode == CAM_MODE_IX2) ? 16'(full_w + idx_w) :
      (mode == CAM_MODE_BSC || mode == CAM_MODE_BTB) ? page0_w :
      CAM_RST_ADDR;
endmodule : cam_ea_calc
`default_nettype wire

// >>> core/cam_read_filter.sv
// read data path: direction registers answer all ones
// assumes read data already settled in the core clock domain
`timescale 1ns/1ps
`default_nettype none
module cam_read_filter #(
   parameter logic [15:0] DDR_FIRST = cam_pkg::CAM_DDR_FIRST,
   parameter logic [15:0] DDR_LAST  = cam_pkg::CAM_DDR_LAST
) (
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  data_out
);
   import cam_pkg::*;

   wire ddr_hit_w = (addr >= DDR_FIRST) && (addr <= DDR_LAST);

   assign data_out = ddr_hit_w ? CAM_DDR_READ : data_in;
endmodule : cam_read_filter
`default_nettype wire

// >>> core/cam_decoder.sv
// instruction decode and effective address generation
// assumes opcode, following bytes, index, pc and read data arrive together
`timescale 1ns/1ps
`default_nettype none
module cam_decoder (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  ce,
   input  wire logic                  instr_valid,
   input  wire logic [7:0]            opcode,
   input  wire logic [7:0]            byte2,
   input  wire logic [7:0]            byte3,
   input  wire logic [7:0]            index_x,
   input  wire logic [15:0]           opcode_pc,
   input  wire logic                  branch_cond,
   input  wire logic [7:0]            operand_byte,
   output logic                       dec_valid,
   output logic                       opcode_legal,
   output var cam_pkg::cam_mode_type  addr_mode,
   output logic      [1:0]            instr_len,
   output logic      [3:0]            cycle_count,
   output logic      [15:0]           effective_address,
   output logic      [7:0]            operand,
   output logic                       mem_read,
   output logic                       mem_write,
   output logic                       acc_write,
   output logic                       idx_write,
   output logic                       flags_only,
   output logic                       pc_load,
   output logic                       push_return,
   output logic      [15:0]           next_pc,
   output logic      [2:0]            bit_num,
   output logic                       bit_value,
   output logic                       carry_load,
   output logic                       carry_value
);
   import cam_pkg::*;

   function automatic cam_mode_type mode_of(input logic [7:0] op);
      case (op[7:4])
         4'h0:        mode_of = CAM_MODE_BTB;
         4'h1:        mode_of = CAM_MODE_BSC;
         4'h2:        mode_of = CAM_MODE_REL;
         4'h3, 4'hb:  mode_of = CAM_MODE_DIR;
         4'h6, 4'he:  mode_of = CAM_MODE_IX1;
         4'h7, 4'hf:  mode_of = CAM_MODE_IX;
         4'ha:        mode_of = (op == CAM_OP_BSR) ? CAM_MODE_REL : CAM_MODE_IMM;
         4'hc:        mode_of = CAM_MODE_EXT;
         4'hd:        mode_of = CAM_MODE_IX2;
         default:     mode_of = CAM_MODE_INH;
      endcase
   endfunction : mode_of

   function automatic logic [1:0] len_of(input cam_mode_type m);
      case (m)
         CAM_MODE_INH, CAM_MODE_IX: len_of = CAM_LEN_ONE;
         CAM_MODE_EXT, CAM_MODE_IX2, CAM_MODE_BTB: len_of = CAM_LEN_THREE;
         default:     len_of = CAM_LEN_TWO;
      endcase
   endfunction : len_of

   function automatic logic [3:0] rm_base(input cam_mode_type m);
      case (m)
         CAM_MODE_IMM: rm_base = CAM_CYC_LD_IMM;
         CAM_MODE_DIR: rm_base = CAM_CYC_LD_DIR;
         CAM_MODE_EXT: rm_base = CAM_CYC_LD_EXT;
         CAM_MODE_IX:  rm_base = CAM_CYC_LD_IX;
         CAM_MODE_IX1: rm_base = CAM_CYC_LD_IX1;
         default:      rm_base = CAM_CYC_LD_IX2;
      endcase
   endfunction : rm_base

   function automatic logic [3:0] cyc_of(input logic [7:0] op,
                                         input cam_mode_type m);
      logic [3:0] b;
      b = rm_base(m);
      if (m == CAM_MODE_BAD)
         cyc_of = CAM_RST_CYC;
      else if (op == CAM_OP_BSR)
         cyc_of = CAM_CYC_BSR;
      else if (op[7:4] >= 4'ha) begin
         if (op[3:0] == CAM_LO_STA || op[3:0] == CAM_LO_STX)
            cyc_of = 4'(b + CAM_CYC_ST_MORE);
         else if (op[3:0] == CAM_LO_JMP)
            cyc_of = 4'(b - CAM_CYC_JMP_LESS);
         else if (op[3:0] == CAM_LO_JSR)
            cyc_of = 4'(b + CAM_CYC_JSR_MORE);
         else
            cyc_of = b;
      end
      else if (op == CAM_OP_RTI)
         cyc_of = CAM_CYC_RTI;
      else if (op == CAM_OP_RTS)
         cyc_of = CAM_CYC_RTS;
      else if (op == CAM_OP_SWI)
         cyc_of = CAM_CYC_SWI;
      else if (op[7:4] == 4'h9)
         cyc_of = CAM_CYC_CTL;
      else begin
         case (m)
            CAM_MODE_BTB: cyc_of = CAM_CYC_BTB;
            CAM_MODE_BSC: cyc_of = CAM_CYC_BSC;
            CAM_MODE_REL: cyc_of = CAM_CYC_REL;
            CAM_MODE_INH: cyc_of = CAM_CYC_RMW_INH;
            CAM_MODE_DIR: cyc_of = CAM_CYC_RMW_DIR;
            CAM_MODE_IX:  cyc_of = CAM_CYC_RMW_IX;
            default:      cyc_of = CAM_CYC_RMW_IX1;
         endcase
      end
   endfunction : cyc_of

   // opcode classes
   wire [3:0] hi_w  = opcode[7:4];
   wire [3:0] lo_w  = opcode[3:0];
   wire is_btb_w    = (hi_w == 4'h0);
   wire is_bsc_w    = (hi_w == 4'h1);
   wire is_bra_w    = (hi_w == 4'h2);
   wire is_bsr_w    = (opcode == CAM_OP_BSR);
   wire is_rmw_w    = (hi_w >= 4'h3) && (hi_w <= 4'h7);
   wire rmw_hole_w  = (lo_w == 4'h1) || (lo_w == 4'h2) || (lo_w == 4'h5) ||
                      (lo_w == 4'hb) || (lo_w == 4'he);
   wire ctl8_ok_w   = (hi_w == 4'h8) && (opcode == CAM_OP_RTI ||
                      opcode == CAM_OP_RTS || opcode == CAM_OP_SWI);
   wire ctl9_ok_w   = (hi_w == 4'h9) && (lo_w >= 4'h7) && (lo_w != 4'he);
   wire is_rm_w     = (hi_w >= 4'ha) && !is_bsr_w;
   wire rm_hole_w   = (hi_w == 4'ha) && (lo_w == CAM_LO_STA ||
                      lo_w == CAM_LO_JMP || lo_w == CAM_LO_STX);
   wire legal_w     = is_btb_w || is_bsc_w || is_bra_w || is_bsr_w ||
                      (is_rmw_w && !rmw_hole_w) || ctl8_ok_w || ctl9_ok_w ||
                      (is_rm_w && !rm_hole_w);

   wire cam_mode_type mode_w = legal_w ? mode_of(opcode) : CAM_MODE_BAD;
   wire [1:0] len_w = len_of(mode_w);
   wire [3:0] cyc_w = cyc_of(opcode, mode_w);

   // register/memory group
   wire rm_ok_w     = is_rm_w && legal_w;
   wire rm_store_w  = rm_ok_w && (lo_w == CAM_LO_STA || lo_w == CAM_LO_STX);
   wire rm_jmp_w    = rm_ok_w && (lo_w == CAM_LO_JMP);
   wire rm_jsr_w    = rm_ok_w && (lo_w == CAM_LO_JSR);
   wire rm_flags_w  = rm_ok_w && (lo_w == CAM_LO_CMPA ||
                      lo_w == CAM_LO_CMPX || lo_w == CAM_LO_BITT);
   wire rm_idx_w    = rm_ok_w && (lo_w == CAM_LO_LDX);
   wire rm_acc_w    = rm_ok_w && !rm_store_w && !rm_jmp_w && !rm_jsr_w &&
                      !rm_flags_w && !rm_idx_w;
   wire rm_read_w   = rm_ok_w && (mode_w != CAM_MODE_IMM) && !rm_store_w &&
                      !rm_jmp_w && !rm_jsr_w;

   // read-modify-write group
   wire rmw_ok_w    = is_rmw_w && legal_w;
   wire rmw_tst_w   = rmw_ok_w && (lo_w == CAM_LO_TST);
   wire rmw_mem_w   = rmw_ok_w && (mode_w != CAM_MODE_INH);
   wire rmw_acc_w   = rmw_ok_w && (hi_w == 4'h4) && !rmw_tst_w;
   wire rmw_idx_w   = rmw_ok_w && (hi_w == 4'h5) && !rmw_tst_w;

   // address and read data
   wire [15:0] ea_w;
   wire [7:0]  rdata_w;

   cam_ea_calc u_ea (
      .mode              (mode_w),
      .byte2             (byte2),
      .byte3             (byte3),
      .index_x           (index_x),
      .effective_address (ea_w)
   );

   cam_read_filter u_rd (
      .addr     (ea_w),
      .data_in  (operand_byte),
      .data_out (rdata_w)
   );

   // bit and branch decisions
   wire [2:0]  bitn_w    = opcode[3:1];
   wire        tested_w  = rdata_w[bitn_w];
   wire        btb_take_w = tested_w ^ opcode[0];
   wire        take_w    = (is_bra_w && branch_cond) || is_bsr_w ||
                           (is_btb_w && btb_take_w);
   wire [7:0]  off_w     = is_btb_w ? byte3 : byte2;
   wire [15:0] seq_pc_w  = 16'(opcode_pc + {14'h0, len_w});
   wire [15:0] tgt_w     = 16'(seq_pc_w + {{8{off_w[7]}}, off_w});
   wire        jump_w    = rm_jmp_w || rm_jsr_w;
   wire        load_w    = jump_w || (legal_w && take_w);
   wire [15:0] nxt_pc    = jump_w ? ea_w : (load_w ? tgt_w : seq_pc_w);
   wire [7:0]  nxt_operand = (mode_w == CAM_MODE_IMM) ? byte2 : rdata_w;
   wire        nxt_read  = rm_read_w || rmw_mem_w || is_bsc_w || is_btb_w;
   wire        nxt_write = rm_store_w || (rmw_mem_w && !rmw_tst_w) ||
                           is_bsc_w;
   wire        cap_w     = ce && instr_valid;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         dec_valid <= 1'b0;
      else if (ce)
         dec_valid <= instr_valid;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         opcode_legal      <= 1'b0;
         addr_mode         <= CAM_MODE_BAD;
         instr_len         <= 2'd0;
         cycle_count       <= CAM_RST_CYC;
         effective_address <= CAM_RST_ADDR;
         operand           <= CAM_RST_BYTE;
         next_pc           <= CAM_RST_ADDR;
         bit_num           <= 3'd0;
         bit_value         <= 1'b0;
         carry_value       <= 1'b0;
      end
      else if (cap_w) begin
         opcode_legal      <= legal_w;
         addr_mode         <= mode_w;
         instr_len         <= len_w;
         cycle_count       <= cyc_w;
         effective_address <= ea_w;
         operand           <= nxt_operand;
         next_pc           <= nxt_pc;
         bit_num           <= bitn_w;
         bit_value         <= ~opcode[0];
         carry_value       <= tested_w;
      end
   end

   // effects, all held off for illegal opcodes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_read    <= 1'b0;
         mem_write   <= 1'b0;
         acc_write   <= 1'b0;
         idx_write   <= 1'b0;
         flags_only  <= 1'b0;
         pc_load     <= 1'b0;
         push_return <= 1'b0;
         carry_load  <= 1'b0;
      end
      else if (cap_w) begin
         mem_read    <= nxt_read;
         mem_write   <= nxt_write;
         acc_write   <= rm_acc_w || rmw_acc_w;
         idx_write   <= rm_idx_w || rmw_idx_w;
         flags_only  <= rm_flags_w || rmw_tst_w;
         pc_load     <= load_w;
         push_return <= rm_jsr_w || is_bsr_w;
         carry_load  <= is_btb_w;
      end
   end

   sequence s_cap(cam_mode_type m);
      cap_w && legal_w && mode_w == m;
   endsequence

   property p_imm;
      @(posedge clk) disable iff (!arst_n)
      s_cap(CAM_MODE_IMM) |=> !mem_read && operand == $past(byte2);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate read memory");

   property p_dir;
      @(posedge clk) disable iff (!arst_n)
      s_cap(CAM_MODE_DIR) |=> effective_address == {8'h00, $past(byte2)} &&
                              instr_len == 2'd2;
   endproperty
   a_dir: assert property (p_dir) else $error("direct address wrong");

   property p_ext;
      @(posedge clk) disable iff (!arst_n)
      s_cap(CAM_MODE_EXT) |=> effective_address == {$past(byte2), $past(byte3)};
   endproperty
   a_ext: assert property (p_ext) else $error("extended address wrong");

   property p_rel;
      @(posedge clk) disable iff (!arst_n)
      cap_w && is_bra_w |=> pc_load == $past(branch_cond) &&
         next_pc == 16'($past(opcode_pc) + 16'd2 +
         (pc_load ? {{8{$past(byte2[7])}}, $past(byte2)} : 16'd0));
   endproperty
   a_rel: assert property (p_rel) else $error("relative branch wrong");

   property p_ix1;
      @(posedge clk) disable iff (!arst_n)
      s_cap(CAM_MODE_IX1) |=>
         effective_address == 16'({8'h00, $past(byte2)} + {8'h00, $past(index_x)});
   endproperty
   a_ix1: assert property (p_ix1) else $error("ix1 address wrong");

   property p_btb;
      @(posedge clk) disable iff (!arst_n)
      s_cap(CAM_MODE_BTB) |=> carry_load && instr_len == 2'd3 &&
         pc_load == (carry_value ^ $past(opcode[0]));
   endproperty
   a_btb: assert property (p_btb) else $error("bit test branch wrong");

   property p_tst;
      @(posedge clk) disable iff (!arst_n)
      cap_w && rmw_tst_w |=> flags_only && !mem_write && !acc_write && !idx_write;
   endproperty
   a_tst: assert property (p_tst) else $error("test wrote result");

   property p_ddr;
      @(posedge clk) disable iff (!arst_n)
      dec_valid && mem_read && effective_address >= CAM_DDR_FIRST &&
      effective_address <= CAM_DDR_LAST |-> operand == CAM_DDR_READ;
   endproperty
   a_ddr: assert property (p_ddr) else $error("ddr read not ones");

   property p_bad;
      @(posedge clk) disable iff (!arst_n)
      cap_w && !legal_w |=> !mem_write && !acc_write && !idx_write && !pc_load;
   endproperty
   a_bad: assert property (p_bad) else $error("illegal opcode acted");

endmodule : cam_decoder
`default_nettype wire

// >>> test/cam_mem_model.sv
// byte-wide memory behind the decoder's read port
// assumes the bench drives the address of the access in flight
`timescale 1ns/1ps
`default_nettype none
module cam_mem_model (
   input  wire logic [15:0] addr,
   output logic      [7:0]  rd_data
);
   // fixed pattern, never all ones at the direction registers
   assign rd_data = addr[7:0] ^ addr[15:8] ^ 8'h3c;
endmodule : cam_mem_model
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the address mode decoder
// assumes a 50 MHz clock and the memory model on the read port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cam_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic instr_valid = 1'b0;
   logic branch_cond = 1'b0;
   logic [7:0] opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00, index_x = 8'h00;
   logic [15:0] opcode_pc = 16'h0100, mem_addr = 16'h0000;
   logic [7:0] operand_byte, operand;
   logic dec_valid, opcode_legal, mem_read, mem_write, acc_write, idx_write;
   logic flags_only, pc_load, push_return, bit_value, carry_load, carry_value;
   cam_mode_type addr_mode;
   logic [1:0] instr_len;
   logic [3:0] cycle_count;
   logic [15:0] effective_address, next_pc;
   logic [2:0] bit_num;
   int compares = 0;
   int miscompares = 0;

   always #10 clk = ~clk;

   cam_mem_model u_mem (.addr(mem_addr), .rd_data(operand_byte));
   cam_decoder u_dut (.clk, .arst_n, .ce, .instr_valid, .opcode, .byte2, .byte3, .index_x,
      .opcode_pc, .branch_cond, .operand_byte, .dec_valid, .opcode_legal, .addr_mode,
      .instr_len, .cycle_count, .effective_address, .operand, .mem_read, .mem_write,
      .acc_write, .idx_write, .flags_only, .pc_load, .push_return, .next_pc, .bit_num,
      .bit_value, .carry_load, .carry_value);

   function automatic logic [7:0] mem_byte(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction : mem_byte

   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // one instruction in, wait for its answer
   task automatic run(input logic [7:0] op, b2, b3, x, input logic cond, input logic [15:0] ea);
      int n;
      @(posedge clk);
      opcode <= op;
      byte2 <= b2;
      byte3 <= b3;
      index_x <= x;
      branch_cond <= cond;
      mem_addr <= ea;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      n = 0;
      #1;
      while (dec_valid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 4) begin
         miscompares++;
         $display("unexpected dec_valid expected 1 seen %b", dec_valid);
         close_out();
      end
   endtask : run

   task automatic cmn(input logic lg, input cam_mode_type md, input logic [1:0] ln,
                      input logic [3:0] cy, input logic [15:0] ea);
      chk("legal", 16'(opcode_legal), 16'(lg));
      chk("mode", 16'(addr_mode), 16'(lg ? md : CAM_MODE_BAD));
      chk("cycles", 16'(cycle_count), 16'(lg ? cy : 4'd0));
      if (lg) chk("length", 16'(instr_len), 16'(ln));
      if (lg && !(md inside {CAM_MODE_IMM, CAM_MODE_INH, CAM_MODE_REL}))
         chk("address", effective_address, ea);
   endtask : cmn

   task automatic t_regmem();
      cam_mode_type md_t [6] = '{CAM_MODE_IMM, CAM_MODE_DIR, CAM_MODE_EXT, CAM_MODE_IX2,
                                 CAM_MODE_IX1, CAM_MODE_IX};
      logic [1:0] ln_t [6] = '{2'd2, 2'd2, 2'd3, 2'd3, 2'd2, 2'd1};
      logic [3:0] cy_t [6] = '{4'd2, 4'd4, 4'd5, 4'd6, 4'd5, 4'd4};
      logic [15:0] ea_t [6] = '{16'h0000, 16'h00ff, 16'hff00, 16'hffff, 16'h01fe, 16'h00ff};
      logic lg;
      logic [3:0] cy;
      for (int i = 0; i < 6; i++) begin
         for (int l = 0; l < 16; l++) begin
            if (i == 0 && l == 13) continue;
            lg = !(i == 0 && (l == 7 || l == 12 || l == 15));
            cy = cy_t[i] + ((l == 7 || l == 15) ? 4'd1 : (l == 12) ? 4'hf : (l == 13) ? 4'd3 : 4'd0);
            run({4'(i + 10), 4'(l)}, 8'hff, 8'h00, 8'hff, 1'b0, ea_t[i]);
            cmn(lg, md_t[i], ln_t[i], cy, ea_t[i]);
            chk("acc_write", 16'(acc_write), 16'(lg && l inside {0, 2, 4, 6, 8, 9, 10, 11}));
            chk("idx_write", 16'(idx_write), 16'(l == 14));
            chk("flags_only", 16'(flags_only), 16'(l inside {1, 3, 5}));
            chk("mem_write", 16'(mem_write), 16'(lg && (l == 7 || l == 15)));
            chk("pc_load", 16'(pc_load), 16'(lg && (l == 12 || l == 13)));
            chk("push_return", 16'(push_return), 16'(lg && l == 13));
            if (i == 0 || l == 6) chk("mem_read", 16'(mem_read), 16'(lg && i != 0));
            if (lg && l < 12 && l != 7 && l != 15)
               chk("operand", 16'(operand), 16'(i == 0 ? 8'hff : mem_byte(ea_t[i])));
            if (lg)
               chk("next_pc", next_pc, (l == 12 || l == 13) ? ea_t[i] : 16'h0100 + 16'(ln_t[i]));
         end
      end
   endtask : t_regmem

   task automatic t_rel();
      logic [7:0] off;
      for (int l = 0; l < 17; l++) begin
         off = l[0] ? 8'h80 : 8'h7f;
         run(l == 16 ? CAM_OP_BSR : {4'h2, 4'(l)}, off, 8'h00, 8'h00, l[1], 16'h0000);
         cmn(1'b1, CAM_MODE_REL, 2'd2, l == 16 ? 4'd8 : 4'd4, 16'h0000);
         chk("next_pc", next_pc, (l[1] || l == 16) ? 16'h0102 + {{8{off[7]}}, off} : 16'h0102);
         chk("push_return", 16'(push_return), 16'(l == 16));
      end
   endtask : t_rel

   task automatic t_bits();
      logic [7:0] a, d;
      for (int n = 0; n < 8; n++) begin
         for (int k = 0; k < 4; k++) begin
            a = 8'h40 + 8'(n * 3);
            d = mem_byte({8'h00, a});
            run(k < 2 ? 8'(16 + 2 * n + k) : 8'(2 * n + k - 2), a, 8'h7f, 8'h00, 1'b0, {8'h00, a});
            cmn(1'b1, k < 2 ? CAM_MODE_BSC : CAM_MODE_BTB, k < 2 ? 2'd2 : 2'd3,
                k < 2 ? 4'd7 : 4'd10, {8'h00, a});
            chk("bit_num", 16'(bit_num), 16'(n));
            if (k < 2) begin
               chk("bit_value", 16'(bit_value), 16'(k == 0));
               chk("mem_write", 16'(mem_write), 16'h0001);
            end else begin
               chk("carry_value", 16'(carry_value), 16'(d[n]));
               chk("carry_load", 16'(carry_load), 16'h0001);
               chk("next_pc", next_pc, (d[n] ^ k[0]) ? 16'h0182 : 16'h0103);
            end
         end
      end
   endtask : t_bits

   task automatic t_rmw();
      cam_mode_type md_t [5] = '{CAM_MODE_DIR, CAM_MODE_INH, CAM_MODE_INH, CAM_MODE_IX1, CAM_MODE_IX};
      logic [1:0] ln_t [5] = '{2'd2, 2'd1, 2'd1, 2'd2, 2'd1};
      logic [3:0] cy_t [5] = '{4'd6, 4'd4, 4'd4, 4'd7, 4'd6};
      logic [15:0] ea_t [5] = '{16'h0020, 16'h0000, 16'h0000, 16'h0030, 16'h0010};
      logic lg;
      for (int i = 0; i < 5; i++) begin
         for (int l = 0; l < 16; l++) begin
            lg = !(l inside {1, 2, 5, 11, 14});
            run({4'(i + 3), 4'(l)}, 8'h20, 8'h00, 8'h10, 1'b0, ea_t[i]);
            cmn(lg, md_t[i], ln_t[i], cy_t[i], ea_t[i]);
            chk("mem_write", 16'(mem_write), 16'(lg && l != 13 && !(i inside {1, 2})));
            chk("flags_only", 16'(flags_only), 16'(lg && l == 13));
            chk("acc_write", 16'(acc_write), 16'(lg && l != 13 && i == 1));
            chk("idx_write", 16'(idx_write), 16'(lg && l != 13 && i == 2));
         end
      end
   endtask : t_rmw

   task automatic t_ctl();
      logic [3:0] cy;
      for (int o = 128; o < 160; o++) begin
         cy = (o == 128) ? 4'd9 : (o == 129) ? 4'd6 : (o == 131) ? 4'd11 :
              (o inside {[151:157], 159}) ? 4'd2 : 4'd0;
         run(8'(o), 8'h00, 8'h00, 8'h00, 1'b0, 16'h0000);
         cmn(cy != 0, CAM_MODE_INH, 2'd1, cy, 16'h0000);
         if (cy == 2) chk("mem_write", 16'(mem_write), 16'h0000);
      end
   endtask : t_ctl

   task automatic t_count();
      int n = 0;
      for (int o = 0; o < 256; o++) begin
         run(8'(o), 8'h20, 8'h00, 8'h10, 1'b0, 16'h0020);
         n += int'(opcode_legal === 1'b1);
      end
      chk("legal count", 16'(n), 16'd207);
      for (int a = 3; a < 8; a++) begin
         run(8'hb6, 8'(a), 8'h00, 8'h00, 1'b0, 16'(a));
         chk("operand", 16'(operand), 16'(a inside {[4:6]} ? 8'hff : mem_byte(16'(a))));
      end
   endtask : t_count

   task automatic t_hold();
      @(posedge clk);
      ce <= 1'b0;
      opcode <= 8'h9d;
      instr_valid <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("frozen valid", 16'(dec_valid), 16'h0000);
      chk("frozen mode", 16'(addr_mode), 16'(CAM_MODE_DIR));
      @(posedge clk);
      instr_valid <= 1'b0;
      ce <= 1'b1;
      arst_n <= 1'b0;
      #1;
      chk("reset mode", 16'(addr_mode), 16'(CAM_MODE_BAD));
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
   endtask : t_hold

   initial begin
      @(posedge clk);
      #1;
      chk("reset valid", 16'(dec_valid), 16'h0000);
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      t_regmem();
      t_rel();
      t_bits();
      t_rmw();
      t_ctl();
      t_count();
      t_hold();
      run(8'ha6, 8'h5a, 8'h00, 8'h00, 1'b0, 16'h0000);
      chk("operand", 16'(operand), 16'h005a);
      close_out();
   end
endmodule : testbench
`default_nettype wire
